/* File: src/cfs_sequencer.sv */
/*
  Bus sequencer for the control-transfer instructions of an 8-bit core.
  Assumes memory returns read data in the same cycle the address is shown.
*/
// Function
// RQ1 - call: six cycles, dummy stack read third
// RQ2 - call pushes high then low byte, writing
// RQ3 - call reads target high last, then jumps
// RQ4 - break: seven cycles, interrupt reuses pc
// RQ5 - fetch cycle reads or forces break
// RQ6 - break pushes high, low, status consecutively
// RQ7 - sixth cycle reads vector low by source
// RQ8 - seventh cycle reads vector high, then jumps
// RQ9 - return interrupt: six cycles, two dummy reads
// RQ10 - pulls status, low, high then fetches
// RQ11 - absolute jump: three cycles to target
// RQ12 - indirect jump: pointer high byte never carries
// RQ13 - return subroutine: dummy reads, pulls low, high
// RQ14 - dummy read at restored, fetch plus one
// RQ15 - branch not taken finishes in two cycles
// RQ16 - taken branch reads target without carry
// RQ17 - page crossing adds corrected-address cycle
// RQ18 - stack pointer down per write, up per read
`default_nettype none
module cfs_sequencer import cfs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // interrupt pins
  input wire logic irq_b,
  input wire logic nmi_b,
  // data bus
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOutEn,
  // address and strobes
  output logic [15:0] addrBus,
  output logic busRead,
  output logic opFetch
);
  localparam cfs_seq_s SEQ_RESET = '{state: ST_T0, op: OP_OTHER, src: SRC_RST,
    pc: PC_RESET, sp: SP_RESET, p: P_RESET, rstPend: 1'b1, irqSync: 2'b11,
    nmiSync: 2'b11, nmiOld: 1'b1, addr: PC_RESET, rd: 1'b1, fetch: 1'b1, default: '0};

  cfs_seq_s r;
  cfs_seq_s n;
  logic irqAct;
  logic nmiEdge;
  logic takeNmi;
  logic taken;
  logic [15:0] pcPush;
  logic [15:0] vecLow;
  logic [15:0] vecHigh;
  cfs_branch_if brBus();

  // ==========================================
  // helpers
  function automatic cfs_seq_s goFetch(input cfs_seq_s s, input logic [15:0] a);
    cfs_seq_s t;
    t = s;
    t.addr = a;
    t.pc = a;
    t.fetch = 1'b1;
    t.state = ST_T0;
    return t;
  endfunction
  // reset entry walks the stack cycles as reads, so memory is left alone
  function automatic cfs_seq_s push(input cfs_seq_s s, input logic [7:0] d, input logic quiet);
    cfs_seq_s t;
    t = s;
    t.addr = {STACK_PAGE, s.sp};
    t.sp = s.sp - 8'h01;
    t.rd = quiet;
    t.doutEn = !quiet;
    t.dout = d;
    return t;
  endfunction
  function automatic cfs_seq_s pull(input cfs_seq_s s);
    cfs_seq_s t;
    t = s;
    t.sp = s.sp + 8'h01;
    t.addr = {STACK_PAGE, s.sp + 8'h01};
    return t;
  endfunction
  function automatic cfs_op_e decode(input logic [7:0] opc);
    cfs_op_e o;
    case (opc)
      OPC_BREAK: o = OP_BRK;
      OPC_CALL: o = OP_CALL;
      OPC_RET_INT: o = OP_RTI;
      OPC_RET_SUB: o = OP_RTS;
      OPC_JUMP_ABS: o = OP_JABS;
      OPC_JUMP_IND: o = OP_JIND;
      default: o = ((opc & BR_MASK) == BR_MATCH) ? OP_BR : OP_OTHER;
    endcase
    return o;
  endfunction
  function automatic logic branchTaken(input logic [7:0] opc, input logic [7:0] p);
    logic f;
    case (opc[BR_SEL_HI:BR_SEL_LO])
      2'b00: f = p[P_N];
      2'b01: f = p[P_V];
      2'b10: f = p[P_C];
      default: f = p[P_Z];
    endcase
    return f == opc[BR_SENSE];
  endfunction

  // ==========================================
  // submodules
  assign brBus.base = r.pc + 16'h0001;
  assign brBus.offset = dataIn;
  cfs_branch_adder uAdder (
    .br(brBus)
  );
  cfs_vector_sel uVector (
    .src(r.src),
    .vecLow(vecLow),
    .vecHigh(vecHigh)
  );

  // ==========================================
  // next state
  always_comb begin
    n = r;
    irqAct = !r.irqSync[1] && !r.p[P_I];
    nmiEdge = r.nmiOld && !r.nmiSync[1];
    takeNmi = 1'b0;
    taken = 1'b0;
    pcPush = (r.src == SRC_BRK) ? r.pc + 16'h0001 : r.pc;
    n.irqSync = {r.irqSync[0], irq_b};
    n.nmiSync = {r.nmiSync[0], nmi_b};
    n.nmiOld = r.nmiSync[1];
    n.fetch = 1'b0;
    n.rd = 1'b1;
    n.doutEn = 1'b0;
    n.state = ST_T0;
    case (r.state)
      ST_T0: begin
        n.state = ST_T1;
        n.opcode = dataIn;
        if (r.rstPend || r.nmiPend || irqAct) begin
          n.op = OP_BRK; // [RQ5]
          n.src = r.rstPend ? SRC_RST : (r.nmiPend ? SRC_NMI : SRC_IRQ);
          takeNmi = !r.rstPend && r.nmiPend;
          n.rstPend = 1'b0;
          n.addr = r.pc; // [RQ4]
        end else begin
          n.op = decode(dataIn); // [RQ5]
          n.src = SRC_BRK;
          n.pc = r.pc + 16'h0001;
          n.addr = r.pc + 16'h0001;
        end
      end
      ST_T1: begin
        n.state = ST_T2;
        case (r.op)
          OP_CALL: begin
            n.tgtLow = dataIn;
            n.pc = r.pc + 16'h0001;
            n.addr = {STACK_PAGE, r.sp}; // [RQ1]
          end
          OP_BRK: begin
            n.pc = pcPush;
            n = push(n, pcPush[15:8], r.src == SRC_RST); // [RQ6] [RQ18]
          end
          OP_RTI, OP_RTS: begin
            n.addr = {STACK_PAGE, r.sp}; // [RQ9] [RQ13]
          end
          OP_JABS, OP_JIND: begin
            n.ptrLow = dataIn;
            n.pc = r.pc + 16'h0001;
            n.addr = r.pc + 16'h0001; // [RQ11] [RQ12]
          end
          OP_BR: begin
            taken = branchTaken(r.opcode, r.p);
            n.pc = brBus.base;
            n.ptrHigh = brBus.fixHigh;
            n.crossed = brBus.crossed;
            if (taken) begin
              n.addr = {brBus.base[15:8], brBus.sumLow}; // [RQ16]
            end else begin
              n = goFetch(n, brBus.base); // [RQ15]
            end
          end
          default: n = goFetch(n, r.pc);
        endcase
      end
      ST_T2: begin
        n.state = ST_T3;
        case (r.op)
          OP_CALL: n = push(n, r.pc[15:8], 1'b0); // [RQ2] [RQ18]
          OP_BRK: n = push(n, r.pc[7:0], r.src == SRC_RST); // [RQ6]
          OP_RTI, OP_RTS: n = pull(n); // [RQ10] [RQ13] [RQ18]
          OP_JABS: n = goFetch(n, {dataIn, r.ptrLow}); // [RQ11]
          OP_JIND: begin
            n.ptrHigh = dataIn;
            n.addr = {dataIn, r.ptrLow}; // [RQ12]
          end
          OP_BR: begin
            if (r.crossed) begin
              n.addr = {r.ptrHigh, r.addr[7:0]}; // [RQ17]
            end else begin
              n = goFetch(n, r.addr); // [RQ16]
            end
          end
          default: n = goFetch(n, r.pc);
        endcase
      end
      ST_T3: begin
        n.state = ST_T4;
        case (r.op)
          OP_CALL: n = push(n, r.pc[7:0], 1'b0); // [RQ2]
          OP_BRK: begin
            n = push(n, (r.p & ~P_B_MASK) | P_U_MASK | ((r.src == SRC_BRK) ? P_B_MASK : 8'h00),
              r.src == SRC_RST); // [RQ6]
          end
          OP_RTI: begin
            n.p = dataIn;
            n = pull(n); // [RQ10]
          end
          OP_RTS: begin
            n.tgtLow = dataIn;
            n = pull(n); // [RQ13]
          end
          OP_JIND: begin
            n.tgtLow = dataIn;
            n.addr = {r.ptrHigh, r.ptrLow + 8'h01}; // [RQ12]
          end
          OP_BR: n = goFetch(n, r.addr); // [RQ17]
          default: n = goFetch(n, r.pc);
        endcase
      end
      ST_T4: begin
        n.state = ST_T5;
        case (r.op)
          OP_CALL: n.addr = r.pc; // [RQ3]
          OP_BRK: begin
            n.addr = vecLow; // [RQ7]
            n.p[P_I] = 1'b1;
          end
          OP_RTI: begin
            n.tgtLow = dataIn;
            n = pull(n); // [RQ10]
          end
          OP_RTS: begin
            n.pc = {dataIn, r.tgtLow};
            n.addr = {dataIn, r.tgtLow}; // [RQ14]
          end
          OP_JIND: n = goFetch(n, {dataIn, r.tgtLow}); // [RQ12]
          default: n = goFetch(n, r.pc);
        endcase
      end
      ST_T5: begin
        case (r.op)
          OP_CALL: n = goFetch(n, {dataIn, r.tgtLow}); // [RQ3]
          OP_BRK: begin
            n.state = ST_T6;
            n.tgtLow = dataIn;
            n.addr = vecHigh; // [RQ8]
          end
          OP_RTI: n = goFetch(n, {dataIn, r.tgtLow}); // [RQ10]
          OP_RTS: n = goFetch(n, r.pc + 16'h0001); // [RQ14]
          default: n = goFetch(n, r.pc);
        endcase
      end
      ST_T6: n = goFetch(n, {dataIn, r.tgtLow}); // [RQ8]
      default: n = goFetch(n, r.pc);
    endcase
    // an edge in the same cycle as the take stays pending
    n.nmiPend = (r.nmiPend && !takeNmi) || nmiEdge;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r <= SEQ_RESET;
    end else begin
      r <= n;
    end
  end

  assign addrBus = r.addr;
  assign busRead = r.rd;
  assign dataOut = r.dout;
  assign dataOutEn = r.doutEn;
  assign opFetch = r.fetch;

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence callStart;
    r.state == ST_T1 && r.op == OP_CALL;
  endsequence
  sequence brkStart;
    r.state == ST_T1 && r.op == OP_BRK && r.src != SRC_RST;
  endsequence
  sequence brkWrites;
    !busRead [*3];
  endsequence

  a_call_bus: assert property (callStart |-> ##1 (busRead && addrBus == {STACK_PAGE, r.sp}) // [RQ1] [RQ2]
    ##1 (!busRead && addrBus == $past(addrBus))
    ##1 (!busRead && addrBus[7:0] == $past(addrBus[7:0]) - 8'h01)
    ##1 busRead ##1 opFetch) else $error("call bus order wrong");
  a_call_target: assert property (r.state == ST_T5 && r.op == OP_CALL |-> // [RQ3]
    busRead && addrBus == r.pc ##1 opFetch && addrBus == {$past(dataIn), r.tgtLow})
    else $error("call target wrong");
  a_brk_seq: assert property (brkStart |-> ##1 brkWrites ##1 busRead [*2] ##1 opFetch) // [RQ4] [RQ6]
    else $error("break sequence wrong");
  a_hw_pc: assert property (r.state == ST_T1 && r.op == OP_BRK && r.src != SRC_BRK |-> // [RQ4]
    addrBus == $past(addrBus)) else $error("interrupt second read not at pc");
  a_vec_nmi: assert property (r.state == ST_T5 && r.op == OP_BRK && r.src == SRC_NMI |-> // [RQ7] [RQ8]
    addrBus == VEC_NMI_LO ##1 addrBus == VEC_NMI_HI ##1 opFetch) else $error("nmi vector wrong");
  a_vec_reset: assert property (r.state == ST_T5 && r.op == OP_BRK && r.src == SRC_RST |-> // [RQ7] [RQ8]
    addrBus == VEC_RST_LO ##1 addrBus == VEC_RST_HI) else $error("reset vector wrong");
  a_rti_reads: assert property (r.state == ST_T1 && r.op == OP_RTI |-> busRead [*5] ##1 opFetch) // [RQ9]
    else $error("return interrupt length wrong");
  a_rti_stack: assert property (r.state == ST_T3 && r.op == OP_RTI |-> // [RQ10]
    addrBus == $past(addrBus) + 16'h0001) else $error("status pull address wrong");
  a_jabs_target: assert property (r.state == ST_T1 && r.op == OP_JABS |=> busRead ##1 // [RQ11]
    (opFetch && addrBus == {$past(dataIn), $past(dataIn, 2)})) else $error("jump target wrong");
  a_jind_page: assert property (r.state == ST_T4 && r.op == OP_JIND |-> // [RQ12]
    addrBus[15:8] == $past(addrBus[15:8]) && addrBus[7:0] == $past(addrBus[7:0]) + 8'h01)
    else $error("pointer increment wrong");
  a_rts_next: assert property (r.state == ST_T5 && r.op == OP_RTS |=> // [RQ13] [RQ14]
    opFetch && addrBus == $past(addrBus) + 16'h0001) else $error("return fetch wrong");
  a_br_skip: assert property (r.state == ST_T1 && r.op == OP_BR && !taken |=> opFetch) // [RQ15]
    else $error("untaken branch too long");
  a_br_nocarry: assert property (r.state == ST_T2 && r.op == OP_BR |-> // [RQ16] [RQ17]
    addrBus[15:8] == r.pc[15:8] && addrBus[7:0] == r.pc[7:0] + $past(dataIn))
    else $error("branch low add wrong");
  a_sp_balance: assert property (r.state == ST_T5 && r.op == OP_CALL |-> // [RQ18]
    r.sp == $past(r.sp, 3) - 8'h02) else $error("stack pointer count wrong");
endmodule
`default_nettype wire

/* File: src/cfs_pkg.sv */
/*
  Shared constants and types for the control-flow bus sequencer.
  Assumes a byte-wide memory on a 16-bit address bus, answered in-cycle.
*/
`default_nettype none
package cfs_pkg;
  // ==========================================
  // bus map
  localparam logic [7:0] STACK_PAGE = 8'h01;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] SP_RESET = 8'hFF;
  localparam logic [7:0] P_RESET = 8'h04;
  localparam logic [15:0] VEC_NMI_LO = 16'hFFFA;
  localparam logic [15:0] VEC_NMI_HI = 16'hFFFB;
  localparam logic [15:0] VEC_RST_LO = 16'hFFFC;
  localparam logic [15:0] VEC_RST_HI = 16'hFFFD;
  localparam logic [15:0] VEC_IRQ_LO = 16'hFFFE;
  localparam logic [15:0] VEC_IRQ_HI = 16'hFFFF;
  // ==========================================
  // status byte
  localparam int P_N = 7;
  localparam int P_V = 6;
  localparam int P_I = 2;
  localparam int P_Z = 1;
  localparam int P_C = 0;
  localparam logic [7:0] P_U_MASK = 8'h20;
  localparam logic [7:0] P_B_MASK = 8'h10;
  // ==========================================
  // opcodes
  localparam logic [7:0] OPC_BREAK = 8'h00;
  localparam logic [7:0] OPC_CALL = 8'h20;
  localparam logic [7:0] OPC_RET_INT = 8'h40;
  localparam logic [7:0] OPC_RET_SUB = 8'h60;
  localparam logic [7:0] OPC_JUMP_ABS = 8'h4C;
  localparam logic [7:0] OPC_JUMP_IND = 8'h6C;
  localparam logic [7:0] BR_MASK = 8'h1F;
  localparam logic [7:0] BR_MATCH = 8'h10;
  localparam int BR_SEL_HI = 7;
  localparam int BR_SEL_LO = 6;
  localparam int BR_SENSE = 5;
  // ==========================================
  // types
  typedef enum logic [2:0] {ST_T0, ST_T1, ST_T2, ST_T3, ST_T4, ST_T5, ST_T6} cfs_state_e;
  typedef enum logic [2:0] {OP_CALL, OP_BRK, OP_RTI, OP_JABS, OP_JIND, OP_RTS, OP_BR, OP_OTHER} cfs_op_e;
  typedef enum logic [1:0] {SRC_BRK, SRC_IRQ, SRC_NMI, SRC_RST} cfs_src_e;
  typedef struct packed {
    cfs_state_e state;
    cfs_op_e op;
    cfs_src_e src;
    logic [7:0] opcode;
    logic [15:0] pc;
    logic [7:0] sp;
    logic [7:0] p;
    logic [7:0] tgtLow;
    logic [7:0] ptrLow;
    logic [7:0] ptrHigh;
    logic crossed;
    logic rstPend;
    logic [1:0] irqSync;
    logic [1:0] nmiSync;
    logic nmiOld;
    logic nmiPend;
    logic [15:0] addr;
    logic rd;
    logic [7:0] dout;
    logic doutEn;
    logic fetch;
  } cfs_seq_s;
endpackage
`default_nettype wire

/* File: src/cfs_branch_if.sv */
/*
  Branch address adder hookup between sequencer and adder.
  Assumes one producer (sequencer) and one purely combinational adder.
*/
`default_nettype none
interface cfs_branch_if;
  logic [15:0] base;
  logic [7:0] offset;
  logic [7:0] sumLow;
  logic [7:0] fixHigh;
  logic crossed;
  modport user(output base, output offset, input sumLow, input fixHigh, input crossed);
  modport unit(input base, input offset, output sumLow, output fixHigh, output crossed);
endinterface
`default_nettype wire

/* File: src/cfs_branch_adder.sv */
/*
  Signed branch offset adder: low byte sum without carry and corrected high byte.
  Assumes the offset is two's complement and base is the address after the offset byte.
*/
`default_nettype none
module cfs_branch_adder (
  // adder operands and results
  cfs_branch_if.unit br
);
  logic [8:0] lowSum;
  logic [7:0] adjust;

  // ==========================================
  // page correction
  always_comb begin
    lowSum = {1'b0, br.base[7:0]} + {1'b0, br.offset};
    adjust = 8'h00;
    if (lowSum[8] && !br.offset[7]) begin
      adjust = 8'h01;
    end else if (!lowSum[8] && br.offset[7]) begin
      adjust = 8'hFF;
    end
  end

  assign br.sumLow = lowSum[7:0];
  assign br.fixHigh = br.base[15:8] + adjust;
  assign br.crossed = (adjust != 8'h00);
endmodule
`default_nettype wire

/* File: src/cfs_vector_sel.sv */
/*
  Interrupt vector address pair per entry source.
  Assumes software break shares the maskable interrupt vector.
*/
`default_nettype none
module cfs_vector_sel import cfs_pkg::*; (
  // entry source
  input wire cfs_src_e src,
  // vector addresses
  output logic [15:0] vecLow,
  output logic [15:0] vecHigh
);
  // ==========================================
  // selection
  always_comb begin
    case (src)
      SRC_NMI: begin
        vecLow = VEC_NMI_LO;
        vecHigh = VEC_NMI_HI;
      end
      SRC_RST: begin
        vecLow = VEC_RST_LO;
        vecHigh = VEC_RST_HI;
      end
      default: begin
        vecLow = VEC_IRQ_LO;
        vecHigh = VEC_IRQ_HI;
      end
    endcase
  end
endmodule
`default_nettype wire

/* File: sim/cfs_mem_model.sv */
/*
  Byte-wide memory standing on the far side of the sequencer's bus.
  Assumes reads are answered in the cycle the address is shown, writes land at the clock edge.
*/
`default_nettype none
module cfs_mem_model (
  // clock
  input wire logic clk,
  // bus from the core
  input wire logic [15:0] addrBus,
  input wire logic busRead,
  input wire logic [7:0] dataOut,
  input wire logic dataOutEn,
  // read data back to the core
  output logic [7:0] dataIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] store [65536];
  logic [7:0] lastRead;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      store[i] = i[7:0] ^ 8'hA5;
    end
    lastRead = 8'h00;
  end
  // ==========================================
  // read path
  // a released bus shows the inverse of the last byte, so a stale capture never matches
  assign dataIn = busRead ? store[addrBus] : ~lastRead;
  always @(posedge clk) begin
    if (busRead) begin
      lastRead <= store[addrBus];
    end else if (dataOutEn) begin
      store[addrBus] <= dataOut;
    end
  end
  // ==========================================
  // bench access
  task automatic load(input logic [15:0] a, input logic [7:0] v);
    store[a] = v;
  endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
/*
  Self-checking bench: predicts every bus cycle of a control-flow program, except those skipped while waiting for reset and NMI entry, and compares.
  Assumes the memory model answers in-cycle and outputs settle before the falling edge.
*/
`default_nettype none
module tb import cfs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [15:0] a; logic r; logic f; logic [7:0] d;} cfs_cyc_s;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  // held low all run: only honoured once the I bit is cleared
  logic irq_b = 1'b0;
  logic nmi_b = 1'b1;
  logic [7:0] dataIn, dataOut;
  logic dataOutEn, busRead, opFetch;
  logic [15:0] addrBus, pc;
  logic [7:0] sp, p, rnd;
  logic [7:0] stk [256];
  cfs_cyc_s q[$];
  int failCount = 0;
  int nChecks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  cfs_sequencer dut (.clk(clk), .rst_b(rst_b), .irq_b(irq_b), .nmi_b(nmi_b), .dataIn(dataIn),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .addrBus(addrBus), .busRead(busRead), .opFetch(opFetch));
  cfs_mem_model mem (.clk(clk), .addrBus(addrBus), .busRead(busRead), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .dataIn(dataIn));

  // ==========================================
  // reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (failCount == 0 && nChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      failCount++;
      $display("wrong value at %0t: run did not finish", $time);
      end_of_test();
    end
  end

  // ==========================================
  // expected-trace builders
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic ex(input logic [15:0] a, input logic r = 1'b1, input logic f = 1'b0, input logic [7:0] d = 8'h00);
    q.push_back('{a, r, f, d});
  endtask
  task automatic push(input logic [7:0] v);
    ex({8'h01, sp}, 1'b0, 1'b0, v);
    stk[sp] = v;
    sp--;
  endtask
  task automatic pull(output logic [7:0] v);
    sp++;
    ex({8'h01, sp});
    v = stk[sp];
  endtask
  task automatic op_start(input logic [7:0] opc);
    mem.load(pc, opc);
    ex(pc, 1'b1, 1'b1);
    ex(pc + 16'h0001);
  endtask
  task automatic op_call(input logic [15:0] t);
    logic [15:0] r;
    r = pc + 16'h0002;
    op_start(OPC_CALL);
    mem.load(pc + 16'h0001, t[7:0]);
    mem.load(r, t[15:8]);
    ex({8'h01, sp});
    push(r[15:8]);
    push(r[7:0]);
    ex(r);
    pc = t;
  endtask
  task automatic op_jabs(input logic [15:0] t);
    op_start(OPC_JUMP_ABS);
    mem.load(pc + 16'h0001, t[7:0]);
    mem.load(pc + 16'h0002, t[15:8]);
    ex(pc + 16'h0002);
    pc = t;
  endtask
  task automatic op_jind(input logic [15:0] ptr, input logic [15:0] t);
    logic [15:0] ptr2;
    // pointer high byte never takes the carry
    ptr2 = {ptr[15:8], ptr[7:0] + 8'h01};
    op_start(OPC_JUMP_IND);
    mem.load(pc + 16'h0001, ptr[7:0]);
    mem.load(pc + 16'h0002, ptr[15:8]);
    mem.load(ptr, t[7:0]);
    mem.load(ptr2, t[15:8]);
    ex(pc + 16'h0002);
    ex(ptr);
    ex(ptr2);
    pc = t;
  endtask
  task automatic op_br(input logic [7:0] opc, input logic [7:0] off);
    logic [15:0] n, t;
    logic [3:0] fl;
    logic taken;
    n = pc + 16'h0002;
    t = n + {{8{off[7]}}, off};
    fl = {p[P_Z], p[P_C], p[P_V], p[P_N]};
    taken = fl[opc[BR_SEL_HI:BR_SEL_LO]] == opc[BR_SENSE];
    op_start(opc);
    mem.load(pc + 16'h0001, off);
    if (taken) begin
      ex({n[15:8], t[7:0]});
      if (t[15:8] != n[15:8]) begin
        ex(t);
      end
    end
    pc = taken ? t : n;
  endtask
  task automatic hw_entry(input logic [15:0] r, input logic [7:0] st, input logic [15:0] vec, input logic [15:0] t);
    mem.load(vec, t[7:0]);
    mem.load(vec + 16'h0001, t[15:8]);
    push(r[15:8]);
    push(r[7:0]);
    push(st);
    ex(vec);
    ex(vec + 16'h0001);
    p[P_I] = 1'b1;
    pc = t;
  endtask
  task automatic op_ret(input logic intr);
    logic [7:0] lo, hi;
    op_start(intr ? OPC_RET_INT : OPC_RET_SUB);
    ex({8'h01, sp});
    if (intr) begin
      pull(p);
    end
    pull(lo);
    pull(hi);
    pc = {hi, lo};
    if (!intr) begin
      ex(pc);
      pc = pc + 16'h0001;
    end
  endtask

  // ==========================================
  // bus comparison
  task automatic run_q();
    cfs_cyc_s e;
    while (q.size() > 0) begin
      @(negedge clk);
      e = q.pop_front();
      check({addrBus, busRead, opFetch, dataOutEn}, {e.a, e.r, e.f, ~e.r});
      if (!e.r) begin
        check(dataOut, e.d);
      end
    end
  endtask
  task automatic seek(input logic [15:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 60 && !hit; i++) begin
      @(negedge clk);
      hit = addrBus === a && busRead === 1'b1 && opFetch === 1'b0;
    end
    check(hit, 1'b1);
  endtask

  initial begin
    logic [7:0] off, lo, pg;
    logic [15:0] loopAt;
    rnd = 8'h0C;
    p = P_RESET;
    repeat (3) @(negedge clk);
    // loaded after time zero so the model's own fill cannot land on top
    mem.load(VEC_RST_LO, 8'h00);
    mem.load(VEC_RST_HI, 8'h02);
    check({addrBus, busRead, opFetch, dataOutEn, dataOut}, {16'h0000, 3'h6, 8'h00});
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    seek(16'h01FF);
    ex(16'h01FE);
    ex(16'h01FD);
    ex(VEC_RST_LO);
    ex(VEC_RST_HI);
    sp = 8'hFC;
    pc = 16'h0200;
    // first branch sits so that its offset crosses a page forward
    op_call(16'h30F0);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr_next(rnd);
      off = (i == 0) ? 8'h7F : (i == 2) ? 8'h80 : (i == 4) ? 8'hF0 : rnd;
      // short backward hops would land on the branch's own bytes
      if (off inside {[8'hF8:8'hFF]}) begin
        off = 8'h08;
      end
      op_br({i[2:0], 5'h10}, off);
      rnd = lfsr_next(rnd);
      lo = (i == 3) ? 8'h05 : rnd;
      pg = 8'h34 + 8'(i * 4);
      op_jabs({pg, lo});
    end
    // an undecoded opcode runs as a two-cycle filler
    op_start(8'hEA);
    pc = pc + 16'h0001;
    rnd = lfsr_next(rnd);
    op_jind(16'h60FF, {8'h54, rnd});
    rnd = lfsr_next(rnd);
    op_jind({8'h62, rnd}, 16'h5880);
    op_ret(1'b0);
    lo = p | P_U_MASK | P_B_MASK;
    loopAt = pc + 16'h0002;
    op_start(OPC_BREAK);
    hw_entry(loopAt, lo, VEC_IRQ_LO, 16'h7800);
    op_ret(1'b1);
    repeat (3) op_jabs(loopAt);
    run_q();
    nmi_b = 1'b0;
    seek(loopAt);
    hw_entry(loopAt, (p | P_U_MASK) & ~P_B_MASK, VEC_NMI_LO, 16'h7000);
    run_q();
    nmi_b = 1'b1;
    // clear the stacked I bit so the held maskable request is taken after return
    mem.load({8'h01, sp + 8'h01}, 8'h00);
    stk[sp + 8'h01] = 8'h00;
    op_ret(1'b1);
    ex(loopAt, 1'b1, 1'b1);
    ex(loopAt);
    hw_entry(loopAt, (p | P_U_MASK) & ~P_B_MASK, VEC_IRQ_LO, 16'h7800);
    ex(16'h7800, 1'b1, 1'b1);
    run_q();
    end_of_test();
  end
endmodule
`default_nettype wire
